// [include/sctu_pkg.sv]
// Constants and types shared by the satellite-link cycle timing unit
package sctu_pkg;
   // Clock and count tick
   localparam int unsigned SCTU_CLK_MHZ   = 200;   // System clock rate
   localparam int unsigned SCTU_TICK_NS   = 2000;  // One count tick, ns
   localparam int unsigned SCTU_TICK_CYC  = (SCTU_TICK_NS * SCTU_CLK_MHZ) / 1000;
   localparam int unsigned SCTU_CNT_W     = 16;    // Counter width
   // Serial bit rates, kbit/s
   localparam int unsigned SCTU_KBPS_FULL  = 1000;
   localparam int unsigned SCTU_KBPS_HALF  = 500;
   localparam int unsigned SCTU_KBPS_MAINT = 125;
   // Bit periods in system cycles
   localparam int unsigned SCTU_BIT_CYC_FULL  = (SCTU_CLK_MHZ * 1000) / SCTU_KBPS_FULL;
   localparam int unsigned SCTU_BIT_CYC_HALF  = (SCTU_CLK_MHZ * 1000) / SCTU_KBPS_HALF;
   localparam int unsigned SCTU_BIT_CYC_MAINT = (SCTU_CLK_MHZ * 1000) / SCTU_KBPS_MAINT;
   // Flag lead-in before a transmission
   localparam int unsigned SCTU_EF_CHARS = 80;
   localparam int unsigned SCTU_EF_BITS  = SCTU_EF_CHARS * 8;
   localparam int unsigned SCTU_EF_TICKS_FULL  =
      SCTU_EF_BITS * (1000000 / SCTU_KBPS_FULL) / SCTU_TICK_NS;
   localparam int unsigned SCTU_EF_TICKS_HALF  =
      SCTU_EF_BITS * (1000000 / SCTU_KBPS_HALF) / SCTU_TICK_NS;
   localparam int unsigned SCTU_EF_TICKS_MAINT =
      SCTU_EF_BITS * (1000000 / SCTU_KBPS_MAINT) / SCTU_TICK_NS;
   // Counter slots
   localparam int SCTU_N_CNT = 7;
   localparam int CNT_CYC = 0;   // cycle_counter
   localparam int CNT_OPN = 1;   // window_open_marker
   localparam int CNT_CLS = 2;   // window_close_marker
   localparam int CNT_MKA = 3;   // optional_mark_a
   localparam int CNT_MKB = 4;   // optional_mark_b
   localparam int CNT_EF  = 5;   // end_flags_event delay
   localparam int CNT_RC  = 6;   // resync_counter
   // Interrupt vector bit positions
   localparam int SCTU_N_IRQ = 7;
   localparam int IRQ_CYC = 0;
   localparam int IRQ_OPN = 1;
   localparam int IRQ_EF  = 2;
   localparam int IRQ_CLS = 3;
   localparam int IRQ_MKA = 4;
   localparam int IRQ_MKB = 5;
   localparam int IRQ_RC  = 6;
   // Synchronisation mode
   typedef enum logic [0:0] {
      SCTU_STARTING = 1'b0,
      SCTU_RUNNING  = 1'b1
   } sctu_mode_t;
endpackage

// [include/sctu_cnt_if.sv]
// Control and status bundle between the unit and one down-counter
`timescale 1ns/1ps
interface sctu_cnt_if #(parameter int W = 16);
   logic         tick;      // Count enable pulse
   logic         restart;   // Reload from initial value
   logic         halt;      // Stop without event
   logic         freerun;   // Reload at zero instead of stopping
   logic [W-1:0] initial_value_reg;       // Initial value
   logic [W-1:0] count;     // Current count
   logic         busy;      // Counter running
   logic         done;      // Reached zero, one cycle
   modport ctl (output tick, restart, halt, freerun, initial_value_reg, input count, busy, done);
   modport cnt (input tick, restart, halt, freerun, initial_value_reg, output count, busy, done);
endinterface

// [rtl/sctu_down_counter.sv]
// Down-counter that reloads from the initial value on its control bundle
`timescale 1ns/1ps
module sctu_down_counter #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   // Control bundle
   sctu_cnt_if.cnt   bus
);
   // Refuse widths the zero test cannot serve
   if (W < 2) begin : g_chk
      $error("sctu_down_counter: W too small");
   end

   typedef struct packed {
      logic [W-1:0] count;   // Present value
      logic         busy;    // Running
      logic         done;    // Zero event
   } sctu_dc_t;

   sctu_dc_t st;        // Registered state
   sctu_dc_t next_st;   // Next state

   // Restart wins over halt and count
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (bus.restart) begin
         next_st.count = bus.initial_value_reg;
         next_st.busy  = 1'b1;
      end else if (bus.halt) begin
         next_st.busy = 1'b0;
      end else if (bus.tick && st.busy) begin
         if (st.count == '0) begin
            next_st.done = 1'b1;
            // Cycle counter reloads itself, markers stop
            if (bus.freerun) begin
               next_st.count = bus.initial_value_reg;
            end else begin
               next_st.busy = 1'b0;
            end
         end else begin
            next_st.count = st.count - 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.count = st.count;
   assign bus.busy  = st.busy;
   assign bus.done  = st.done;

   property p_reload_at_zero;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (st.busy && bus.tick && st.count == '0 && bus.freerun && !bus.restart && !bus.halt)
      |=> (st.count == $past(bus.initial_value_reg)) && st.busy && st.done;
   endproperty
   a_reload_at_zero: assert property (p_reload_at_zero)
      else $error("free-running counter did not reload");

   property p_oneshot_stops;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (st.done && !bus.freerun && !$past(bus.freerun) && !bus.restart) |=> !st.busy;
   endproperty
   a_oneshot_stops: assert property (p_oneshot_stops)
      else $error("one-shot counter kept running");
endmodule

// [rtl/sctu_timing_unit.sv]
// Cycle timing unit: cycle, transmit window, markers and slave sync
// Overview of operation
// - Repeating cycle, nominally 75 ms
// - Transmit only while own window is open
// - Window setting loaded when station enabled
// - Slave aligns cycle to master bursts
// - Slave cycle free-runs when bursts are missing
// - Optional marks enabled individually, every marker with maskable interrupt
// - Cycle-counter terminal count starts each cycle
// - Open, end-flags, close in order, once
// - Open to close marker defines window
// - Optional marks silent unless enabled
// - 16-bit down-counters reload from initial values
// - One count tick is 2 us
// - Maintenance: loop tx to rx, 125 kbit/s
// - Counters advance at one fixed tick rate
// - End-flags 80 characters after open, rate-scaled
// - Starting: edge reloads, trailing edge tests window
// - Running: resync every second cycle, halts interrupt
`timescale 1ns/1ps
module sctu_timing_unit
   import sctu_pkg::*;
#(
   parameter int CNT_W = SCTU_CNT_W
) (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  resetn_i,
   // Station control from the computer
   input  wire logic                  enable_i,
   input  wire logic                  slave_i,
   input  wire logic                  half_rate_i,
   input  wire logic                  maint_i,
   input  wire logic                  mark_a_en_i,
   input  wire logic                  mark_b_en_i,
   input  wire logic [SCTU_N_IRQ-1:0] irq_mask_i,
   // Initial values, in 2 us ticks
   input  wire logic [CNT_W-1:0]      cycle_ivr_i,
   input  wire logic [CNT_W-1:0]      open_ivr_i,
   input  wire logic [CNT_W-1:0]      close_ivr_i,
   input  wire logic [CNT_W-1:0]      mark_a_ivr_i,
   input  wire logic [CNT_W-1:0]      mark_b_ivr_i,
   input  wire logic [CNT_W-1:0]      resync_ivr_i,
   input  wire logic [CNT_W-1:0]      sync_window_start_i,
   input  wire logic [CNT_W-1:0]      sync_window_end_i,
   // Serial data
   input  wire logic                  rx_line_i,
   input  wire logic                  tx_data_i,
   // Outputs
   output logic                       rx_data_o,
   output logic                       bit_en_o,
   output logic                       tx_window_o,
   output logic [SCTU_N_IRQ-1:0]      irq_o,
   output logic                       running_o,
   output logic                       resync_hit_o,
   output logic [CNT_W-1:0]           resync_value_o
);
   // Counters are exactly 16 bits wide
   if (CNT_W != SCTU_CNT_W) begin : g_chk
      $error("sctu_timing_unit: CNT_W must be 16");
   end

   localparam logic [10:0] BIT_FULL  = 11'(SCTU_BIT_CYC_FULL - 1);
   localparam logic [10:0] BIT_HALF  = 11'(SCTU_BIT_CYC_HALF - 1);
   localparam logic [10:0] BIT_MAINT = 11'(SCTU_BIT_CYC_MAINT - 1);
   localparam logic [8:0]  TICK_LAST = 9'(SCTU_TICK_CYC - 1);

   // Ticks elapsed since a counter was loaded
   function automatic logic [CNT_W-1:0] elapsed(input logic [CNT_W-1:0] initial_value_reg,
                                               input logic [CNT_W-1:0] cnt);
      elapsed = initial_value_reg - cnt;
   endfunction

   // Inside the sync window, bounds inclusive
   function automatic logic in_win(input logic [CNT_W-1:0] t);
      in_win = (t >= sync_window_start_i) && (t <= sync_window_end_i);
   endfunction

   // End-flags delay for the active bit rate
   function automatic logic [CNT_W-1:0] ef_ticks(input logic mnt, input logic half);
      if (mnt) begin
         ef_ticks = CNT_W'(SCTU_EF_TICKS_MAINT);
      end else if (half) begin
         ef_ticks = CNT_W'(SCTU_EF_TICKS_HALF);
      end else begin
         ef_ticks = CNT_W'(SCTU_EF_TICKS_FULL);
      end
   endfunction

   typedef struct packed {
      sctu_mode_t            mode;       // Sync mode
      logic                  lead_seen;  // Awaiting trailing edge
      logic                  parity;     // Every second cycle
      logic                  rc_armed;   // Resync search running
      logic                  win_open;   // Transmit window
      logic                  win_done;   // Window used this cycle
      logic                  en_q;       // Enable, delayed
      logic [CNT_W-1:0]      open_ivr;   // Latched window setting
      logic [CNT_W-1:0]      close_ivr;
      logic                  rx_q;       // Previous rx level
      logic                  rx_data;
      logic [8:0]            tick_div;
      logic                  tick;
      logic [10:0]           bit_div;
      logic                  bit_en;
      logic [SCTU_N_IRQ-1:0] irq;
      logic                  rc_hit;
      logic [CNT_W-1:0]      rc_value;
   } sctu_state_t;

   sctu_state_t st;        // Registered state
   sctu_state_t next_st;   // Next state

   sctu_cnt_if #(.W(CNT_W)) cif[SCTU_N_CNT] ();

   // One counter per slot, all on the same tick
   for (genvar i = 0; i < SCTU_N_CNT; i++) begin : g_cnt
      assign cif[i].tick = st.tick;
      sctu_down_counter #(.W(CNT_W)) u_cnt (
         .sys_clk_i (sys_clk_i),
         .resetn_i  (resetn_i),
         .bus       (cif[i])
      );
   end

   logic rx_src;      // Line or looped-back data
   logic rx_rise;     // Leading edge
   logic rx_fall;     // Trailing edge
   logic starting;    // Slave still searching
   logic rc_hit_now;  // Burst found in resync window
   logic rc_start;    // Resync counter restart

   assign rx_src   = maint_i ? tx_data_i : rx_line_i;
   assign rx_rise  = rx_src && !st.rx_q;
   assign rx_fall  = !rx_src && st.rx_q;
   assign starting = slave_i && (st.mode == SCTU_STARTING);
   // Resync on every second cycle boundary, slaves only
   assign rc_start = cif[CNT_CYC].done && slave_i && !starting && st.parity;
   assign rc_hit_now = st.rc_armed && rx_rise &&
                       in_win(elapsed(resync_ivr_i, cif[CNT_RC].count));

   // Cycle counter: free running; leading edges reload it while starting
   assign cif[CNT_CYC].restart = !cif[CNT_CYC].busy || (starting && rx_rise);
   assign cif[CNT_CYC].halt    = 1'b0;
   assign cif[CNT_CYC].freerun = 1'b1;
   assign cif[CNT_CYC].initial_value_reg     = cycle_ivr_i;
   // Window markers start at each boundary with the latched setting
   assign cif[CNT_OPN].restart = cif[CNT_CYC].done && st.en_q;
   assign cif[CNT_OPN].halt    = 1'b0;
   assign cif[CNT_OPN].freerun = 1'b0;
   assign cif[CNT_OPN].initial_value_reg     = st.open_ivr;
   assign cif[CNT_CLS].restart = cif[CNT_CYC].done && st.en_q;
   assign cif[CNT_CLS].halt    = 1'b0;
   assign cif[CNT_CLS].freerun = 1'b0;
   assign cif[CNT_CLS].initial_value_reg     = st.close_ivr;
   // Optional marks only run when enabled
   assign cif[CNT_MKA].restart = cif[CNT_CYC].done && mark_a_en_i;
   assign cif[CNT_MKA].halt    = !mark_a_en_i;
   assign cif[CNT_MKA].freerun = 1'b0;
   assign cif[CNT_MKA].initial_value_reg     = mark_a_ivr_i;
   assign cif[CNT_MKB].restart = cif[CNT_CYC].done && mark_b_en_i;
   assign cif[CNT_MKB].halt    = !mark_b_en_i;
   assign cif[CNT_MKB].freerun = 1'b0;
   assign cif[CNT_MKB].initial_value_reg     = mark_b_ivr_i;
   // End-flags delay starts as the window opens
   assign cif[CNT_EF].restart  = cif[CNT_OPN].done && !st.win_done;
   assign cif[CNT_EF].halt     = cif[CNT_CLS].done;
   assign cif[CNT_EF].freerun  = 1'b0;
   assign cif[CNT_EF].initial_value_reg      = ef_ticks(maint_i, half_rate_i);
   // Resync counter stops on a hit or at its limit
   assign cif[CNT_RC].restart  = rc_start;
   assign cif[CNT_RC].halt     = rc_hit_now;
   assign cif[CNT_RC].freerun  = 1'b0;
   assign cif[CNT_RC].initial_value_reg      = resync_ivr_i;

   // Next-state logic
   always_comb begin
      logic [SCTU_N_IRQ-1:0] ev;   // Raw events this cycle
      ev      = '0;
      next_st = st;
      next_st.rx_q    = rx_src;
      next_st.rx_data = rx_src;
      next_st.en_q    = enable_i;
      // Count tick divider
      next_st.tick     = (st.tick_div == TICK_LAST);
      next_st.tick_div = next_st.tick ? '0 : st.tick_div + 1'b1;
      // Serial bit-rate enable
      next_st.bit_en  = 1'b0;
      next_st.bit_div = st.bit_div + 1'b1;
      if (st.bit_div >= (maint_i ? BIT_MAINT : (half_rate_i ? BIT_HALF : BIT_FULL))) begin
         next_st.bit_en  = 1'b1;
         next_st.bit_div = '0;
      end
      // Enabling loads the window setting and picks the mode
      if (enable_i && !st.en_q) begin
         next_st.open_ivr  = open_ivr_i;
         next_st.close_ivr = close_ivr_i;
         next_st.mode      = slave_i ? SCTU_STARTING : SCTU_RUNNING;
         next_st.lead_seen = 1'b0;
      end else if (!slave_i) begin
         next_st.mode = SCTU_RUNNING;   // Master never tunes
      end
      // Cycle boundary
      if (cif[CNT_CYC].done) begin
         ev[IRQ_CYC]      = 1'b1;
         next_st.parity   = !st.parity;
         next_st.win_done = 1'b0;
      end
      // Window sequence: open, end-flags, close, once per cycle
      if (cif[CNT_OPN].done && !st.win_done) begin
         next_st.win_open = st.en_q;
         next_st.win_done = 1'b1;
         ev[IRQ_OPN]      = 1'b1;
      end
      if (cif[CNT_EF].done && st.win_open) begin
         ev[IRQ_EF] = 1'b1;
      end
      if (cif[CNT_CLS].done || !st.en_q) begin
         next_st.win_open = 1'b0;
         ev[IRQ_CLS]      = cif[CNT_CLS].done && st.win_open;
      end
      ev[IRQ_MKA] = cif[CNT_MKA].done;
      ev[IRQ_MKB] = cif[CNT_MKB].done;
      // Starting mode: test the trailing edge after a reload
      if (starting) begin
         if (rx_rise) begin
            next_st.lead_seen = 1'b1;
         end else if (rx_fall && st.lead_seen) begin
            next_st.lead_seen = 1'b0;
            if (in_win(elapsed(cycle_ivr_i, cif[CNT_CYC].count))) begin
               next_st.mode = SCTU_RUNNING;
            end else begin
               ev[IRQ_RC]     = 1'b1;   // No hit
               next_st.rc_hit = 1'b0;
            end
         end
      end
      // Running mode: resync search every second cycle
      if (rc_start) begin
         next_st.rc_armed = 1'b1;
      end else if (rc_hit_now || (st.rc_armed && cif[CNT_RC].done)) begin
         next_st.rc_armed = 1'b0;
         next_st.rc_hit   = rc_hit_now;
         next_st.rc_value = elapsed(resync_ivr_i, cif[CNT_RC].count);
         ev[IRQ_RC]       = 1'b1;
      end
      next_st.irq = ev & irq_mask_i;
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign rx_data_o      = st.rx_data;
   assign bit_en_o       = st.bit_en;
   assign tx_window_o    = st.win_open;
   assign irq_o          = st.irq;
   assign running_o      = (st.mode == SCTU_RUNNING);
   assign resync_hit_o   = st.rc_hit;
   assign resync_value_o = st.rc_value;

   sequence s_cycle_start;
      cif[CNT_CYC].done && st.en_q;
   endsequence

   property p_tick_gap;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      st.tick |=> !st.tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("count ticks too close");

   property p_markers_follow_cycle;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      s_cycle_start |=> cif[CNT_OPN].busy && cif[CNT_CLS].busy
                        && cif[CNT_OPN].count == $past(st.open_ivr);
   endproperty
   a_markers_follow_cycle: assert property (p_markers_follow_cycle)
      else $error("window markers not restarted at cycle boundary");

   property p_window_opens;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (cif[CNT_OPN].done && st.en_q && enable_i && !st.win_done && !cif[CNT_CLS].done)
      |=> st.win_open && (irq_o[IRQ_OPN] == $past(irq_mask_i[IRQ_OPN]));
   endproperty
   a_window_opens: assert property (p_window_opens)
      else $error("window did not open on open marker");

   property p_one_window;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (st.win_done && !cif[CNT_CYC].done) |=> !$rose(st.win_open);
   endproperty
   a_one_window: assert property (p_one_window)
      else $error("second window in one cycle");

   property p_ef_in_window;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      st.irq[IRQ_EF] |-> $past(st.win_open) && $past(cif[CNT_EF].done);
   endproperty
   a_ef_in_window: assert property (p_ef_in_window)
      else $error("end-flags event outside window");

   property p_mark_off;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      !mark_a_en_i |=> !cif[CNT_MKA].busy && !st.irq[IRQ_MKA];
   endproperty
   a_mark_off: assert property (p_mark_off)
      else $error("disabled mark produced activity");

   property p_rc_second_cycle;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      rc_start |=> cif[CNT_RC].busy && st.rc_armed && !st.parity;
   endproperty
   a_rc_second_cycle: assert property (p_rc_second_cycle)
      else $error("resync counter not started");

   property p_loopback;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      maint_i |=> rx_data_o == $past(tx_data_i);
   endproperty
   a_loopback: assert property (p_loopback)
      else $error("maintenance loopback broken");

   property p_start_reload;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (starting && rx_rise) |=> cif[CNT_CYC].count == $past(cycle_ivr_i);
   endproperty
   a_start_reload: assert property (p_start_reload)
      else $error("leading edge did not reload cycle counter");
endmodule

// [verif/sctu_modem_model.sv]
// Earth-station modem model that drives the receive-data line with bursts
`timescale 1ns/1ps
module sctu_modem_model (
   // Clock
   input  wire logic        sys_clk_i,
   // Burst request from the bench
   input  wire logic        go_i,
   input  wire logic [15:0] len_i,
   // Receive data toward the unit
   output logic             rx_line_o
);
   logic [15:0] left = 16'h0000;  // Burst cycles still to send

   // Idle line rests low; a burst is one high level of len_i cycles
   always @(posedge sys_clk_i) begin
      if (go_i && left == 16'h0000) begin
         left      <= len_i;
         rx_line_o <= 1'b1;
      end else if (left > 16'h0001) begin
         left <= left - 16'h0001;
      end else begin
         left      <= 16'h0000;
         rx_line_o <= 1'b0;
      end
   end
endmodule

// [verif/satlink_cycle_timing_unit_bench.sv]
// Self-checking bench for the satellite-link cycle timing unit
`timescale 1ns/1ps
module satlink_cycle_timing_unit_bench;
   import sctu_pkg::*;
   localparam int TQ  = 400;     // Cycles per 2 us count tick
   localparam int LIM = 100000;  // Run ceiling in cycles
   // One timing case: event, rate selects, delay from reference, window level
   typedef struct {
      int   ev;     // Irq bit, 7 selects bit_en_o
      logic half;   // Half rate select
      logic maint;  // Maintenance select
      int   dly;    // Cycles from reference
      logic win;    // Window level at the event
   } sctu_row_t;
   sctu_row_t rows [7] = '{
      '{0, 1'b0, 1'b0, 15 * TQ, 1'b0},  // Cycle period
      '{1, 1'b0, 1'b0, 4 * TQ, 1'b1},   // Open, latched value
      '{4, 1'b0, 1'b0, 5 * TQ, 1'b1},   // Mark A inside window
      '{3, 1'b0, 1'b0, 8 * TQ, 1'b0},   // Close
      '{7, 1'b0, 1'b0, 200, 1'b0},      // 1.0 Mbit/s
      '{7, 1'b1, 1'b0, 400, 1'b0},      // 0.5 Mbit/s
      '{7, 1'b0, 1'b1, 1600, 1'b0}      // 125 kbit/s
   };
   // Design inputs
   logic                  sys_clk_i, resetn_i, enable_i, slave_i, half_rate_i, maint_i;
   logic                  mark_a_en_i, mark_b_en_i, tx_data_i, rx_line_i;
   logic [SCTU_N_IRQ-1:0] irq_mask_i;
   logic [15:0]           cyc_ivr, opn_ivr, cls_ivr, mka_ivr, mkb_ivr, rc_ivr, sw_lo, sw_hi;
   // Design outputs
   logic                  rx_data_o, bit_en_o, tx_window_o, running_o, resync_hit_o;
   logic [SCTU_N_IRQ-1:0] irq_o;
   logic [15:0]           resync_value_o;
   // Modem burst request
   logic                  go;
   logic [15:0]           len;
   // Bookkeeping
   int                    error_cnt = 0, tests_run = 0, cyc = 0, t0, h0, h6;
   int                    hits [8] = '{default: 0};  // Pulses seen per event

   sctu_timing_unit uut (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .enable_i(enable_i), .slave_i(slave_i),
      .half_rate_i(half_rate_i), .maint_i(maint_i), .mark_a_en_i(mark_a_en_i),
      .mark_b_en_i(mark_b_en_i), .irq_mask_i(irq_mask_i), .cycle_ivr_i(cyc_ivr),
      .open_ivr_i(opn_ivr), .close_ivr_i(cls_ivr), .mark_a_ivr_i(mka_ivr),
      .mark_b_ivr_i(mkb_ivr), .resync_ivr_i(rc_ivr), .sync_window_start_i(sw_lo),
      .sync_window_end_i(sw_hi), .rx_line_i(rx_line_i), .tx_data_i(tx_data_i),
      .rx_data_o(rx_data_o), .bit_en_o(bit_en_o), .tx_window_o(tx_window_o), .irq_o(irq_o),
      .running_o(running_o), .resync_hit_o(resync_hit_o), .resync_value_o(resync_value_o)
   );
   sctu_modem_model modem (.sys_clk_i(sys_clk_i), .go_i(go), .len_i(len), .rx_line_o(rx_line_i));

   // 200 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // Verdict and end of run
   task automatic complete_run();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Compare and count; four-state so unknowns never match
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask
   // One event pulse; index 7 selects the bit strobe
   function automatic logic ev(input int i);
      return (i == 7) ? bit_en_o : irq_o[i[2:0]];
   endfunction
   // Advance n edges, then settle a fixed delay past the edge
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // Bounded wait for the next pulse of an event
   task automatic wait_ev(input int i, input int lim);
      int n;
      n = 0;
      do begin
         step(1);
         n++;
      end while (ev(i) !== 1'b1 && n < lim);
      check("event seen", 1, ev(i));
   endtask
   // Ask the modem for one burst of n cycles
   task automatic burst(input logic [15:0] n);
      len = n;
      go  = 1'b1;
      step(1);
      go  = 1'b0;
   endtask
   // Cycle count, pulse tally and run ceiling
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 8; i++) begin
         if (ev(i) === 1'b1) begin
            hits[i] <= hits[i] + 1;
         end
      end
      if (cyc == LIM) begin
         error_cnt++;
         complete_run();
      end
   end

   // Main sequence
   initial begin
      {resetn_i, enable_i, slave_i, half_rate_i, maint_i, tx_data_i, go} = 7'h00;
      {mark_a_en_i, mark_b_en_i} = 2'b10;
      irq_mask_i = 7'h7f;
      {cyc_ivr, opn_ivr, cls_ivr, mka_ivr} = {16'h000e, 16'h0003, 16'h0007, 16'h0004};
      {mkb_ivr, rc_ivr, sw_lo, sw_hi, len} = {16'h0002, 16'h0003, 16'h0002, 16'h0005, 16'h0000};
      step(2);
      check("reset outputs", 0, {irq_o, tx_window_o, running_o, bit_en_o});
      resetn_i = 1'b1;
      step(2);
      // Master station; window value taken at enable, later change ignored
      enable_i = 1'b1;
      step(1);
      opn_ivr = 16'h000a;
      foreach (rows[r]) begin
         half_rate_i = rows[r].half;
         maint_i     = rows[r].maint;
         if (rows[r].ev == 7) begin
            wait_ev(7, 2000);
         end
         wait_ev((rows[r].ev == 7) ? 7 : IRQ_CYC, 7000);
         t0 = cyc;
         wait_ev(rows[r].ev, 7000);
         check("delay", rows[r].dly, cyc-t0);
         if (rows[r].ev < 7) begin
            check("tx window", rows[r].win, tx_window_o);
         end
      end
      // Close comes before end-flags could; master never resyncs
      check("idle", 0, hits[IRQ_EF]+hits[IRQ_MKB]+hits[IRQ_RC]);
      // Masked mark A stays silent, enabled mark B fires once a cycle
      irq_mask_i[IRQ_MKA] = 1'b0;
      mark_b_en_i         = 1'b1;
      wait_ev(IRQ_CYC, 7000);
      h0 = hits[IRQ_MKA];
      h6 = hits[IRQ_MKB];
      step(6000);
      check("masked mark", h0, hits[IRQ_MKA]);
      check("enabled mark", h6 + 1, hits[IRQ_MKB]);
      irq_mask_i[IRQ_MKA] = 1'b1;
      mark_b_en_i         = 1'b0;
      // Maintenance loopback, one cycle late
      maint_i = 1'b1;
      for (int k = 0; k < 4; k++) begin
         tx_data_i = k[0];
         step(1);
         check("loopback", k[0], rx_data_o);
      end
      // Slave: re-enable in starting mode, short burst misses the sync window
      {maint_i, slave_i, enable_i} = 3'b010;
      step(1);
      enable_i = 1'b1;
      step(2);
      check("starting mode", 0, running_o);
      burst(16'h0064);
      wait_ev(IRQ_RC, 200);
      check("no hit", 0, {running_o, resync_hit_o});
      // Burst ending inside the window locks the cycle
      burst(16'h0578);
      step(1410);
      check("locked", 1, running_o);
      // No further bursts: cycle runs on, resync misses every second cycle
      wait_ev(IRQ_CYC, 7000);
      h0 = hits[IRQ_CYC];
      h6 = hits[IRQ_RC];
      step(12000);
      check("free cycles", h0 + 2, hits[IRQ_CYC]);
      check("resync halts", h6 + 1, hits[IRQ_RC]);
      check("resync miss", 0, resync_hit_o);
      // A miss halts at the limit, so the whole limit has elapsed
      check("resync value", rc_ivr, resync_value_o);
      // Reset in mid-run clears everything at once
      resetn_i = 1'b0;
      step(1);
      check("reset outputs", 0, {irq_o, tx_window_o, running_o, bit_en_o});
      // Release again: slave restarts searching, no stray events at once
      resetn_i = 1'b1;
      step(2);
      check("after release", 0, {irq_o, tx_window_o, running_o, bit_en_o});
      complete_run();
   end
endmodule
